// ### logic/thsa_core.sv
// Hit selection and amplitude measurement control with its register file
//
// Overview of operation
// [RULE1] Edge code 00 times rising hit edges, code 01 times falling edges.
// [RULE2] Code 10 alternates edge every measurement cycle, 11 every second one.
// [RULE3] Store bit 0 writes sum only; 1 adds first eight hit results.
// [RULE4] Hit count field gives 1 to 31 hits per measurement; zero forbidden.
// [RULE5] Skip field discards 0 to 3 detected hits between used hits.
// [RULE6] Count start mode begins at programmed number of hits after first.
// [RULE7] Start-mode bit 0 selects by count, bit 1 selects by delay.
// [RULE8] Pulse-width detection runs only while its enable bit is set.
// [RULE9] Calibration rate 000 disables, 001 every measurement, higher less often.
// [RULE10] Timeout field must be all ones; amplitude run aborts after 128 us.
// [RULE11] Peak detection ends after Nth detected hit, N from 1 to 31.
// [RULE12] Unused upper register bits are ignored on write and read zero.
`timescale 1ns/1ps
`default_nettype none
module thsa_core (
    input  wire logic             i_clk_sys,
    input  wire logic             i_arst_n,
    input  wire logic             i_ce,
    input  wire logic [7:0]       i_addr,
    input  wire logic [31:0]      i_wdata,
    input  wire logic             i_wr,
    input  wire logic             i_rd,
    output logic [31:0]           o_rdata,
    input  wire logic             i_cmp,
    input  wire logic             i_tof_start,
    input  wire logic             i_dly_done,
    input  wire logic             i_am_start,
    output logic                  o_edge_falling,
    output logic                  o_tof_hit,
    output logic                  o_tof_busy,
    output logic                  o_tof_done,
    output var thsa_pkg::thsa_rbuf_wr_s o_rbuf,
    output logic                  o_pwd_enable,
    output logic                  o_am_cal,
    output logic                  o_peak_active,
    output logic                  o_am_done,
    output logic                  o_am_abort
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    thsa_pkg::thsa_tof_cfg_s tof_cfg_reg;
    thsa_pkg::thsa_am_cfg_s  am_cfg_reg;
    thsa_pkg::thsa_tof_e     tof_state_reg;
    thsa_pkg::thsa_tof_e     tof_state_next;
    thsa_pkg::thsa_am_e      am_state_reg;
    logic [31:0] rdata_reg;
    logic        alt_reg;
    logic        pair_reg;
    logic        edge_reg;
    logic [4:0]  seek_cnt_reg;
    logic [1:0]  skip_cnt_reg;
    logic [4:0]  taken_reg;
    logic [15:0] time_reg;
    logic [31:0] sum_reg;
    logic [4:0]  am_hits_reg;
    logic [11:0] am_timer_reg;
    logic [6:0]  cal_cnt_reg;
    logic        cal_reg;
    logic        am_done_reg;
    logic        am_abort_reg;
    logic        tof_hit_reg;
    thsa_pkg::thsa_rbuf_wr_s rbuf_reg;
    logic        hit_rise;
    logic        hit_fall;
    logic        eff_fall;
    logic        hit_det;
    logic        take;
    logic        take_last;
    logic        am_end;
    logic        am_tmo;
    logic [6:0]  cal_div;

    localparam logic [11:0] AM_TMO_LAST = 12'(thsa_pkg::AM_TMO_CYC - 1);

    // ------------------------------------------------------------
    // Comparator input
    // ------------------------------------------------------------
    thsa_sync u_sync (
        .i_clk_sys (i_clk_sys),
        .i_arst_n  (i_arst_n),
        .i_ce      (i_ce),
        .i_async   (i_cmp),
        .o_rise    (hit_rise),
        .o_fall    (hit_fall)
    );

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tof_cfg_reg <= thsa_pkg::TOF_CFG_RST;
            am_cfg_reg  <= thsa_pkg::AM_CFG_RST;
        end else if (i_ce && i_wr) begin
            // [RULE12] Upper half dropped
            if (i_addr == thsa_pkg::TOF_CFG_OFS) begin
                tof_cfg_reg <= i_wdata[15:0];
            end
            if (i_addr == thsa_pkg::AM_CFG_OFS) begin
                am_cfg_reg <= i_wdata[15:0];
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rdata_reg <= 32'h0000_0000;
        end else if (i_ce) begin
            rdata_reg <= 32'h0000_0000;
            if (i_rd) begin
                unique case (i_addr)
                    // [RULE12] Upper bits read zero
                    thsa_pkg::TOF_CFG_OFS: rdata_reg <= {16'h0000, tof_cfg_reg};
                    thsa_pkg::AM_CFG_OFS:  rdata_reg <= {16'h0000, am_cfg_reg};
                    thsa_pkg::STATUS_OFS:  rdata_reg <= {20'h00000, am_state_reg, alt_reg,
                                                         tof_state_reg, edge_reg, taken_reg, 2'h0};
                    default:               rdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Edge selection
    // ------------------------------------------------------------
    // [RULE1] Fixed polarity codes
    assign eff_fall = tof_cfg_reg.hit_edge_select[1] ? alt_reg
                                                     : tof_cfg_reg.hit_edge_select[0];
    assign hit_det  = eff_fall ? hit_fall : hit_rise;

    // Polarity only flips between cycles, never inside one
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            alt_reg  <= 1'b0;
            pair_reg <= 1'b0;
        end else if (i_ce && tof_state_reg == thsa_pkg::TOF_DONE) begin
            // [RULE2] Alternate after cycles
            if (tof_cfg_reg.hit_edge_select == 2'h2) begin
                alt_reg <= ~alt_reg;
            end else if (tof_cfg_reg.hit_edge_select == 2'h3) begin
                pair_reg <= ~pair_reg;
                if (pair_reg) begin
                    alt_reg <= ~alt_reg;
                end
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            edge_reg <= 1'b0;
        end else if (i_ce) begin
            edge_reg <= eff_fall;
        end
    end

    // ------------------------------------------------------------
    // Hit selection
    // ------------------------------------------------------------
    // [RULE7] Start by count or by delay
    // [RULE6] Offset counted from first hit
    // [RULE5] Skipped hits between taken ones
    always_comb begin
        take = 1'b0;
        if (hit_det && tof_state_reg == thsa_pkg::TOF_SEEK) begin
            take = tof_cfg_reg.start_hit_by_delay ? i_dly_done
                                                  : (seek_cnt_reg == tof_cfg_reg.start_hit_offset);
        end else if (hit_det && tof_state_reg == thsa_pkg::TOF_RUN) begin
            take = (skip_cnt_reg == tof_cfg_reg.skipped_hit_count);
        end
    end

    // [RULE4] Stop after programmed hit count
    assign take_last = take && (5'(taken_reg + 5'h01) == tof_cfg_reg.measured_hit_count);

    always_comb begin
        tof_state_next = tof_state_reg;
        unique case (tof_state_reg)
            thsa_pkg::TOF_IDLE: if (i_tof_start) tof_state_next = thsa_pkg::TOF_SEEK;
            thsa_pkg::TOF_SEEK: begin
                if (take_last) begin
                    tof_state_next = thsa_pkg::TOF_DONE;
                end else if (take) begin
                    tof_state_next = thsa_pkg::TOF_RUN;
                end
            end
            thsa_pkg::TOF_RUN:  if (take_last) tof_state_next = thsa_pkg::TOF_DONE;
            thsa_pkg::TOF_DONE: tof_state_next = thsa_pkg::TOF_IDLE;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tof_state_reg <= thsa_pkg::TOF_IDLE;
        end else if (i_ce) begin
            tof_state_reg <= tof_state_next;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            seek_cnt_reg <= 5'h00;
            skip_cnt_reg <= 2'h0;
            taken_reg    <= 5'h00;
            time_reg     <= 16'h0000;
            sum_reg      <= 32'h0000_0000;
        end else if (i_ce) begin
            if (tof_state_reg == thsa_pkg::TOF_IDLE) begin
                seek_cnt_reg <= 5'h00;
                skip_cnt_reg <= 2'h0;
                time_reg     <= 16'h0000;
                if (i_tof_start) begin
                    taken_reg <= 5'h00;
                    sum_reg   <= 32'h0000_0000;
                end
            end else begin
                time_reg <= 16'(time_reg + 16'h0001);
                if (take) begin
                    taken_reg    <= 5'(taken_reg + 5'h01);
                    sum_reg      <= 32'(sum_reg + {16'h0000, time_reg});
                    skip_cnt_reg <= 2'h0;
                end else if (hit_det) begin
                    seek_cnt_reg <= 5'(seek_cnt_reg + 5'h01);
                    skip_cnt_reg <= 2'(skip_cnt_reg + 2'h1);
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Result buffer writes
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rbuf_reg    <= '0;
            tof_hit_reg <= 1'b0;
        end else if (i_ce) begin
            tof_hit_reg    <= take;
            rbuf_reg.valid <= 1'b0;
            // [RULE3] Sum always, single hits on request
            if (tof_state_reg == thsa_pkg::TOF_DONE) begin
                rbuf_reg.valid <= 1'b1;
                rbuf_reg.addr  <= 4'h0;
                rbuf_reg.data  <= sum_reg;
            end else if (take && tof_cfg_reg.store_individual_hits
                         && taken_reg < 5'(thsa_pkg::IND_HITS)) begin
                rbuf_reg.valid <= 1'b1;
                rbuf_reg.addr  <= 4'(taken_reg + 5'h01);
                rbuf_reg.data  <= {16'h0000, time_reg};
            end
        end
    end

    // ------------------------------------------------------------
    // Amplitude measurement
    // ------------------------------------------------------------
    // [RULE11] End after Nth detected hit
    assign am_end = am_state_reg == thsa_pkg::AM_PEAK && hit_det
                    && 5'(am_hits_reg + 5'h01) == am_cfg_reg.peak_detect_end_hit;
    // [RULE10] Fixed 128 us abort
    assign am_tmo = am_state_reg == thsa_pkg::AM_PEAK && !am_end && am_timer_reg == AM_TMO_LAST;

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            am_state_reg <= thsa_pkg::AM_IDLE;
            am_hits_reg  <= 5'h00;
            am_timer_reg <= 12'h000;
            am_done_reg  <= 1'b0;
            am_abort_reg <= 1'b0;
        end else if (i_ce) begin
            am_done_reg  <= am_end;
            am_abort_reg <= am_tmo;
            unique case (am_state_reg)
                thsa_pkg::AM_IDLE: begin
                    am_hits_reg  <= 5'h00;
                    am_timer_reg <= 12'h000;
                    if (i_am_start) am_state_reg <= thsa_pkg::AM_PEAK;
                end
                thsa_pkg::AM_PEAK: begin
                    am_timer_reg <= 12'(am_timer_reg + 12'h001);
                    if (hit_det) am_hits_reg <= 5'(am_hits_reg + 5'h01);
                    if (am_end || am_tmo) am_state_reg <= thsa_pkg::AM_IDLE;
                end
            endcase
        end
    end

    // Divisor table follows the other rate fields of the device
    always_comb begin
        unique case (am_cfg_reg.amplitude_cal_rate)
            3'h0, 3'h1: cal_div = 7'h01;
            3'h2:       cal_div = 7'h02;
            3'h3:       cal_div = 7'h05;
            3'h4:       cal_div = 7'h0A;
            3'h5:       cal_div = 7'h14;
            3'h6:       cal_div = 7'h32;
            3'h7:       cal_div = 7'h64;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cal_cnt_reg <= 7'h00;
            cal_reg     <= 1'b0;
        end else if (i_ce) begin
            cal_reg <= 1'b0;
            if (i_am_start && am_state_reg == thsa_pkg::AM_IDLE) begin
                // [RULE9] Rate 000 never calibrates
                cal_reg     <= am_cfg_reg.amplitude_cal_rate != 3'h0 && cal_cnt_reg == 7'h00;
                cal_cnt_reg <= (7'(cal_cnt_reg + 7'h01) >= cal_div) ? 7'h00
                                                                   : 7'(cal_cnt_reg + 7'h01);
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_rdata        = rdata_reg;
    assign o_edge_falling = edge_reg;
    assign o_tof_hit      = tof_hit_reg;
    assign o_tof_busy     = tof_state_reg != thsa_pkg::TOF_IDLE;
    assign o_tof_done     = tof_state_reg == thsa_pkg::TOF_DONE;
    assign o_rbuf         = rbuf_reg;
    // [RULE8] Detection gated by enable
    assign o_pwd_enable   = am_cfg_reg.pulse_width_detect_on;
    assign o_am_cal       = cal_reg;
    assign o_peak_active  = am_state_reg == thsa_pkg::AM_PEAK;
    assign o_am_done      = am_done_reg;
    assign o_am_abort     = am_abort_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_fixed_edge;
        i_ce && !tof_cfg_reg.hit_edge_select[1] && !i_wr;
    endsequence

    property p_fixed_edge;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        s_fixed_edge |=> o_edge_falling == $past(tof_cfg_reg.hit_edge_select[0]);
    endproperty
    a_fixed_edge: assert property (p_fixed_edge) else $error("edge mismatch"); // [RULE1]

    property p_toggle;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_ce && o_tof_done && tof_cfg_reg.hit_edge_select == 2'h2) |=> alt_reg != $past(alt_reg);
    endproperty
    a_toggle: assert property (p_toggle) else $error("edge did not alternate"); // [RULE2]

    property p_single_store;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (o_rbuf.valid && o_rbuf.addr != 4'h0) |-> o_rbuf.addr <= 4'h8 && tof_cfg_reg.store_individual_hits;
    endproperty
    a_single_store: assert property (p_single_store) else $error("stray single hit write"); // [RULE3]

    property p_count;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        o_tof_done |-> taken_reg == tof_cfg_reg.measured_hit_count ##1 o_rbuf.valid && o_rbuf.addr == 4'h0;
    endproperty
    a_count: assert property (p_count) else $error("wrong hit count or sum"); // [RULE4]

    property p_skip;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (take && tof_state_reg == thsa_pkg::TOF_RUN) |-> skip_cnt_reg == tof_cfg_reg.skipped_hit_count;
    endproperty
    a_skip: assert property (p_skip) else $error("skip count wrong"); // [RULE5]

    property p_start_cnt;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (take && tof_state_reg == thsa_pkg::TOF_SEEK && !tof_cfg_reg.start_hit_by_delay)
            |-> seek_cnt_reg == tof_cfg_reg.start_hit_offset ##1 o_tof_hit;
    endproperty
    a_start_cnt: assert property (p_start_cnt) else $error("start hit offset wrong"); // [RULE6]

    property p_start_dly;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (tof_state_reg == thsa_pkg::TOF_SEEK && tof_cfg_reg.start_hit_by_delay && !i_dly_done) |-> !take;
    endproperty
    a_start_dly: assert property (p_start_dly) else $error("start before delay"); // [RULE7]

    property p_pwd;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_ce && i_wr && i_addr == thsa_pkg::AM_CFG_OFS) |=> o_pwd_enable == $past(i_wdata[15]);
    endproperty
    a_pwd: assert property (p_pwd) else $error("pulse width enable wrong"); // [RULE8]

    property p_cal_off;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_ce && am_cfg_reg.amplitude_cal_rate == 3'h0) |=> !o_am_cal;
    endproperty
    a_cal_off: assert property (p_cal_off) else $error("calibration while disabled"); // [RULE9]

    sequence s_tmo_hit;
        i_ce && am_tmo;
    endsequence

    property p_tmo;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        s_tmo_hit |-> am_timer_reg == 12'(thsa_pkg::AM_TMO_CYC - 1) ##1 o_am_abort && !o_peak_active;
    endproperty
    a_tmo: assert property (p_tmo) else $error("timeout abort wrong"); // [RULE10]

    property p_peak_end;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_ce && o_peak_active && hit_det && 5'(am_hits_reg + 5'h01) == am_cfg_reg.peak_detect_end_hit)
            |=> o_am_done && !o_peak_active;
    endproperty
    a_peak_end: assert property (p_peak_end) else $error("peak detect did not end"); // [RULE11]
endmodule
`default_nettype wire

// ### logic/thsa_pkg.sv
// Constants and carriers of the hit select and amplitude configuration block
package thsa_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0]  TOF_CFG_OFS  = 8'hCA;
    localparam logic [7:0]  AM_CFG_OFS   = 8'hCB;
    localparam logic [7:0]  STATUS_OFS   = 8'hF0;
    localparam logic [15:0] TOF_CFG_RST  = 16'h0000;
    localparam logic [15:0] AM_CFG_RST   = 16'h0000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_KHZ     = 20000;
    localparam int AM_TMO_US   = 128;
    localparam int AM_TMO_CYC  = (AM_TMO_US * CLK_KHZ) / 1000;
    localparam int IND_HITS    = 8;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TOF_IDLE = 2'b00,
        TOF_SEEK = 2'b01,
        TOF_RUN  = 2'b11,
        TOF_DONE = 2'b10
    } thsa_tof_e;

    typedef enum logic {
        AM_IDLE = 1'b0,
        AM_PEAK = 1'b1
    } thsa_am_e;

    // Layout equals bits 15:0 of the time-of-flight register
    typedef struct packed {
        logic [1:0] hit_edge_select;
        logic       store_individual_hits;
        logic [4:0] measured_hit_count;
        logic [1:0] skipped_hit_count;
        logic [4:0] start_hit_offset;
        logic       start_hit_by_delay;
    } thsa_tof_cfg_s;

    // Layout equals bits 15:0 of the amplitude register
    typedef struct packed {
        logic       pulse_width_detect_on;
        logic [2:0] amplitude_cal_rate;
        logic [2:0] timeout_code;
        logic [4:0] peak_detect_end_hit;
        logic [3:0] other_bits;
    } thsa_am_cfg_s;

    typedef struct packed {
        logic        valid;
        logic [3:0]  addr;
        logic [31:0] data;
    } thsa_rbuf_wr_s;
endpackage

// ### logic/thsa_sync.sv
// Two-stage synchroniser with edge pulses for the comparator input
`timescale 1ns/1ps
`default_nettype none
module thsa_sync (
    input  wire logic i_clk_sys,
    input  wire logic i_arst_n,
    input  wire logic i_ce,
    input  wire logic i_async,
    output logic      o_rise,
    output logic      o_fall
);
    logic meta_reg;
    logic sync_reg;
    logic prev_reg;

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else if (i_ce) begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign o_rise = sync_reg & ~prev_reg;
    assign o_fall = ~sync_reg & prev_reg;
endmodule
`default_nettype wire

// ### test/thsa_core_tb.sv
// Register, hit selection and amplitude tests of the configuration block
`timescale 1ns/1ps
`default_nettype none
module thsa_core_tb;
    localparam logic [7:0] TOF = thsa_pkg::TOF_CFG_OFS;
    localparam logic [7:0] AMR = thsa_pkg::AM_CFG_OFS;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        ce = 1'b1;
    logic        tgo = 1'b0;
    logic        ago = 1'b0;
    logic        dly = 1'b0;
    logic        fire = 1'b0;
    logic [5:0]  np = 6'h00;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic        cmp, fall, hit, busy, done, pwd, cal, peak, amd, abt;
    thsa_pkg::thsa_rbuf_wr_s rbuf;
    int fail_count = 0, samples_checked = 0;
    int n_hit, n_buf, n_cal, n_done, n_amd, n_abt, n_cyc, t_abt;
    logic [3:0]  last_a;
    logic [31:0] last_d;
    always #25 clk = ~clk;
    thsa_rx_model u_rx (.i_clk_sys(clk), .i_fire(fire), .i_pulses(np), .o_cmp(cmp));
    thsa_core u_dut (.i_clk_sys(clk), .i_arst_n(rst_n), .i_ce(ce), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_cmp(cmp), .i_tof_start(tgo), .i_dly_done(dly),
        .i_am_start(ago), .o_edge_falling(fall), .o_tof_hit(hit), .o_tof_busy(busy), .o_tof_done(done),
        .o_rbuf(rbuf), .o_pwd_enable(pwd), .o_am_cal(cal), .o_peak_active(peak), .o_am_done(amd),
        .o_am_abort(abt));
    always @(posedge clk) begin
        n_cyc++;
        n_hit += (hit === 1'b1);
        n_done += (done === 1'b1);
        n_cal += (cal === 1'b1);
        n_amd += (amd === 1'b1);
        if (abt === 1'b1) t_abt = n_cyc;
        n_abt += (abt === 1'b1);
        if (rbuf.valid === 1'b1) {last_a, last_d} = {rbuf.addr, rbuf.data};
        n_buf += (rbuf.valid === 1'b1);
    end
    // ------------------------------------------------------------
    // Bus and run tasks
    // ------------------------------------------------------------
    // Wide enough for three packed counters at once
    task automatic check(input logic [95:0] seen, input logic [95:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 check(rdata, exp);
    endtask
    task automatic reset;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
    endtask
    // Start one side or just a burst, then wait bounded for idle
    task automatic run(input logic t, input logic a, input logic [5:0] p);
        {n_hit, n_buf, n_cal, n_done, n_amd, n_abt, t_abt} = '0;
        @(posedge clk);
        {tgo, ago, fire, np} <= {t, a, 1'b1, p};
        @(posedge clk);
        {tgo, ago, fire} <= 3'b000;
        n_cyc = 0;
        repeat (3000) begin
            @(posedge clk);
            if (busy === 1'b0 && peak === 1'b0 && n_cyc > 80) break;
        end
        repeat (3) @(posedge clk);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        results();
    end
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        reset();
        rreg(TOF, 32'h0);
        rreg(8'h55, 32'h0);
        wreg(TOF, 32'hFFFF_2242);
        rreg(TOF, 32'h0000_2242);
        // Write while frozen must be lost
        @(posedge clk);
        ce <= 1'b0;
        wreg(TOF, 32'h0000_0000);
        ce <= 1'b1;
        rreg(TOF, 32'h0000_2242);
        run(1'b1, 1'b0, 6'h06);
        check(n_hit, 2);
        check(n_buf, 3);
        check(last_a, 0);
        check(last_d, 32'h0000_0026);
        wreg(TOF, 32'h0000_0280);
        run(1'b1, 1'b0, 6'h04);
        check({n_hit, n_buf, n_done}, {32'd2, 32'd1, 32'd1});
        check(last_d, 32'h0000_001E);
        wreg(TOF, 32'h0000_02C0);
        run(1'b1, 1'b0, 6'h04);
        check(busy, 1);
        reset();
        wreg(TOF, 32'h0000_0101);
        run(1'b1, 1'b0, 6'h03);
        check(n_hit, 0);
        dly <= 1'b1;
        run(1'b0, 1'b0, 6'h02);
        check({n_hit, n_done}, {32'd1, 32'd1});
        dly <= 1'b0;
        for (int c = 0; c < 4; c++) begin
            reset();
            wreg(TOF, {16'h0, c[1:0], 14'h0100});
            for (int i = 1; i < 5; i++) begin
                run(1'b1, 1'b0, 6'h02);
                check(fall, c == 0 ? 0 : c == 1 ? 1 : c == 2 ? i % 2 : (i / 2) % 2);
            end
        end
        wreg(AMR, 32'h0000_9E30);
        rreg(AMR, 32'h0000_9E30);
        check(pwd, 1);
        run(1'b0, 1'b1, 6'h05);
        check({n_cal, n_amd, n_abt}, {32'd1, 32'd1, 32'd0});
        wreg(AMR, 32'h0000_0E30);
        #1 check(pwd, 0);
        run(1'b0, 1'b1, 6'h00);
        check({n_cal, n_amd, n_abt}, {32'd0, 32'd0, 32'd1});
        check(t_abt >= 2559 && t_abt <= 2563, 1);
        results();
    end
endmodule
`default_nettype wire

// ### test/thsa_rx_model.sv
// Comparator hit source standing in for the receive path
`timescale 1ns/1ps
`default_nettype none
module thsa_rx_model (
    input  wire logic       i_clk_sys,
    input  wire logic       i_fire,
    input  wire logic [5:0] i_pulses,
    output logic            o_cmp
);
    logic [5:0] left = 6'h00;
    logic [2:0] ph = 3'h0;
    initial o_cmp = 1'b0;
    // Square burst, four high four low; rests low between bursts
    always @(posedge i_clk_sys) begin
        if (i_fire) begin
            left <= i_pulses;
            ph <= 3'h0;
        end else if (left != 6'h00) begin
            ph <= ph + 3'h1;
            o_cmp <= (ph < 3'h4);
            if (ph == 3'h7) left <= left - 6'h01;
        end else o_cmp <= 1'b0;
    end
endmodule
`default_nettype wire
